// [verif/host_model.sv]
`timescale 1ns/10ps
// ==========================================
// register bus master standing for the host
module host_model (
  input wire logic clk,
  input wire logic awready,
  output logic awvalid,
  output logic [31:0] awaddr,
  input wire logic wready,
  output logic wvalid,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  input wire logic bvalid,
  output logic bready,
  input wire logic [1:0] bresp,
  input wire logic arready,
  output logic arvalid,
  output logic [31:0] araddr,
  input wire logic rvalid,
  output logic rready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp
);
  initial begin
    awvalid = 1'b0;
    awaddr = 32'h0000_0000;
    wvalid = 1'b0;
    wdata = 32'h0000_0000;
    wstrb = 4'hF;
    bready = 1'b0;
    arvalid = 1'b0;
    araddr = 32'h0000_0000;
    rready = 1'b0;
  end
  // address and data offered together, each dropped once taken
  task automatic wr(input logic [31:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [31:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rd
endmodule : host_model

// [verif/tb_top.sv]
`timescale 1ns/10ps
`include "cond_unit_consts.svh"
module tb_top;
  import cond_unit_pkg::*;
  // short millisecond so stamps stay cheap to simulate
  localparam int unsigned MS = 4;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] din = 8'h00;
  logic aw_v, aw_r, w_v, w_r, b_v, b_r, ar_v, ar_r, r_v, r_r;
  logic [31:0] aw_a, w_d, ar_a, r_d;
  logic [3:0] w_s;
  logic [1:0] b_p, r_p;
  cc_t cc;
  logic jump;
  logic [11:0] jtgt;
  int num_errors = 0;
  int compares = 0;
  int jumps = 0;
  logic [31:0] seed = 32'h3388_c543;
  always #12.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (jump === 1'b1) jumps <= jumps + 1;
  cond_unit #(.MS_CYCLES(MS)) u_cond_unit (
    .CLK_SYS(clk_sys), .NRST(nrst), .DIN(din),
    .S_AXI_AWVALID(aw_v), .S_AXI_AWREADY(aw_r), .S_AXI_AWADDR(aw_a),
    .S_AXI_AWPROT(3'h0), .S_AXI_WVALID(w_v), .S_AXI_WREADY(w_r),
    .S_AXI_WDATA(w_d), .S_AXI_WSTRB(w_s), .S_AXI_BVALID(b_v),
    .S_AXI_BREADY(b_r), .S_AXI_BRESP(b_p), .S_AXI_ARVALID(ar_v),
    .S_AXI_ARREADY(ar_r), .S_AXI_ARADDR(ar_a), .S_AXI_ARPROT(3'h0),
    .S_AXI_RVALID(r_v), .S_AXI_RREADY(r_r), .S_AXI_RDATA(r_d),
    .S_AXI_RRESP(r_p), .COND_CODE(cc), .JUMP_TAKEN(jump),
    .JUMP_TARGET(jtgt));
  host_model u_host_model (
    .clk(clk_sys), .awready(aw_r), .awvalid(aw_v), .awaddr(aw_a),
    .wready(w_r), .wvalid(w_v), .wdata(w_d), .wstrb(w_s),
    .bvalid(b_v), .bready(b_r), .bresp(b_p), .arready(ar_r),
    .arvalid(ar_v), .araddr(ar_a), .rvalid(r_v), .rready(r_r),
    .rdata(r_d), .rresp(r_p));
  // ==========================================
  // expectation helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic logic [31:0] ad(logic [7:0] i);
    return {22'h0, i, 2'b00};
  endfunction : ad
  function automatic logic [31:0] mk(op_t o, logic [2:0] s, logic l,
                                     reg_sel_t r, cc_t c, logic [11:0] t);
    return {7'h0, t, c, r, l, s, o};
  endfunction : mk
  function automatic cc_t cmp(logic signed [31:0] a,
                              logic signed [31:0] b);
    return (a < b) ? CC_L : ((a == b) ? CC_E : CC_G);
  endfunction : cmp
  // ==========================================
  // compares and bus wrappers
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic chk_rsp(string n, logic [1:0] e, logic [1:0] g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : chk_rsp
  task automatic rchk(string n, logic [31:0] a, logic [31:0] e,
                      logic [1:0] er = `RESP_OKAY);
    logic [31:0] d;
    logic [1:0] p;
    u_host_model.rd(a, d, p);
    chk_rsp({n, " rresp"}, er, p);
    chk(n, e, d);
  endtask : rchk
  task automatic wchk(logic [31:0] a, logic [31:0] d,
                      logic [1:0] er = `RESP_OKAY);
    logic [1:0] p;
    u_host_model.wr(a, d, p);
    chk_rsp("bresp", er, p);
  endtask : wchk
  task automatic op(logic [31:0] c);
    wchk(ad(`IDX_CMD), c);
  endtask : op
  // gap of 4g+2 cycles keeps the stamp clear of prescaler phase
  task automatic fire(int g);
    din[3] <= 1'b1;
    repeat (2) @(posedge clk_sys);
    din[3] <= 1'b0;
    repeat (4 * g) @(posedge clk_sys);
  endtask : fire
  task automatic report_and_stop();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (20000) @(posedge clk_sys);
    num_errors++;
    report_and_stop();
  end
  // ==========================================
  // main sequence
  initial begin
    logic [31:0] l, v, t;
    logic signed [31:0] sv;
    cc_t e;
    int n;
    int gaps[10];
    repeat (10) @(posedge clk_sys);
    nrst <= 1'b1;
    rchk("cond rst", ad(`IDX_COND), CC_F);
    rchk("status rst", ad(`IDX_STATUS), 32'h0000_0010);
    rchk("cmd rst", ad(`IDX_CMD), 32'h0000_0000);
    rchk("trig rst", ad(`IDX_TRIG_CNT), 32'h0000_0000);
    rchk("ts rst", ad(`IDX_TS_RESULT), 32'h0000_0000);
    rchk("unmapped", ad(8'h06), 32'h0000_0000, `RESP_SLVERR);
    wchk(32'h0000_0400, 32'h0000_0001, `RESP_SLVERR);
    for (int i = 0; i < 16; i++) begin
      l = rnd();
      din <= l[15:8];
      repeat (4) @(posedge clk_sys);
      e = (l[8 + (i % 8)] == l[0]) ? CC_T : CC_F;
      op(mk(OP_INPUT_TEST, i[2:0], l[0], RS_TS_RESULT, CC_F, 12'h000));
      chk("cc port", e, cc);
      rchk("in test", ad(`IDX_COND), e);
    end
    wchk(ad(`IDX_COND), {29'h0, ~e});
    rchk("cond ro", ad(`IDX_COND), e);
    for (int i = 0; i < 8; i++) begin
      v = rnd();
      if (i[0]) begin
        t = i[1] ? v : rnd();
        if (t == `LONG_BAD) t = 32'h0000_0001;
        wchk(ad(`IDX_TS_RESULT), v);
        e = cmp(v, t);
      end else begin
        sv = v[15] ? -$signed({18'h0, v[13:0]}) : {18'h0, v[13:0]};
        t = sv + (i / 2) % 3 - 1;
        wchk(ad(`IDX_TRIG_CNT), {16'h0, sv[15:0]});
        e = cmp(sv, t);
      end
      wchk(ad(`IDX_TEST_VAL), t);
      op(mk(OP_REG_TEST, 3'h0, 1'b0, i[0] ? RS_TS_RESULT : RS_TRIG_CNT,
            CC_F, 12'h000));
      rchk("reg test", ad(`IDX_COND), e);
    end
    wchk(ad(`IDX_TEST_VAL), 32'h0000_8000);
    op(mk(OP_REG_TEST, 3'h0, 1'b0, RS_TRIG_CNT, CC_F, 12'h000));
    rchk("short bad", ad(`IDX_COND), e);
    rchk("err set", ad(`IDX_STATUS), 32'h0000_0050);
    wchk(ad(`IDX_STATUS), 32'h0000_0040);
    wchk(ad(`IDX_TEST_VAL), `LONG_BAD);
    op(mk(OP_REG_TEST, 3'h0, 1'b0, RS_TS_RESULT, CC_F, 12'h000));
    rchk("long bad", ad(`IDX_COND), e);
    rchk("err set", ad(`IDX_STATUS), 32'h0000_0050);
    wchk(ad(`IDX_STATUS), 32'h0000_0040);
    wchk(ad(`IDX_TRIG_CNT), 32'h0000_7FFF);
    wchk(ad(`IDX_TEST_VAL), `SHORT_MAX);
    op(mk(OP_REG_TEST, 3'h0, 1'b0, RS_TRIG_CNT, CC_F, 12'h000));
    rchk("short max", ad(`IDX_COND), CC_E);
    rchk("err clear", ad(`IDX_STATUS), 32'h0000_0010);
    wchk(ad(`IDX_TEST_VAL), 32'h0000_0000);
    op(mk(OP_REG_TEST, 3'h0, 1'b0, RS_ELAPSED, CC_F, 12'h000));
    rchk("elapsed", ad(`IDX_COND), CC_G);
    din <= 8'h5A;
    wchk(ad(`IDX_TEST_VAL), 32'h0000_005A);
    op(mk(OP_REG_TEST, 3'h0, 1'b0, RS_INPUTS, CC_F, 12'h000));
    rchk("inputs", ad(`IDX_COND), CC_E);
    for (int c = 0; c < 5; c++) begin
      n = jumps;
      op(mk(OP_COND_JUMP, 3'h0, 1'b0, RS_TS_RESULT, cc_t'(c), 12'h100 + c));
      repeat (2) @(posedge clk_sys);
      chk("jump pulses", (c == 3) ? 1 : 0, jumps - n);
      chk("jump port", (c >= 3) ? 32'h0000_0103 : 32'h0, jtgt);
      rchk("jump reg", ad(`IDX_JUMP), (c >= 3) ? 32'h0000_0103 : 32'h0);
    end
    din <= 8'h00;
    repeat (4) @(posedge clk_sys);
    op(mk(OP_TRIG_SETUP, 3'd3, 1'b1, RS_TS_RESULT, CC_F, 12'h000));
    fire(1);
    fire(1);
    rchk("two stamps", ad(`IDX_STATUS), 32'h0000_0082);
    op(mk(OP_TRIG_SETUP, 3'd3, 1'b1, RS_TS_RESULT, CC_F, 12'h000));
    rchk("flushed", ad(`IDX_STATUS), 32'h0000_0090);
    wchk(ad(`IDX_TRIG_CNT), 32'h0000_0000);
    for (int i = 0; i < 10; i++) begin
      gaps[i] = (rnd() % 4) + 1;
      fire(gaps[i]);
    end
    rchk("full", ad(`IDX_STATUS), 32'h0000_00A8);
    rchk("trig count", ad(`IDX_TRIG_CNT), 32'h0000_000A);
    for (int j = 0; j < 9; j++) begin
      op(mk(OP_TS_POP, 3'h0, 1'b0, RS_TS_RESULT, CC_F, 12'h000));
      repeat (3) @(posedge clk_sys);
      if (j > 0) begin
        t = (j < 8) ? gaps[j - 1] : 0;
        rchk("stamp", ad(`IDX_TS_RESULT), t);
      end
    end
    rchk("drained", ad(`IDX_STATUS), 32'h0000_0090);
    op(mk(OP_TRIG_SETUP, 3'd3, 1'b0, RS_TS_RESULT, CC_F, 12'h000));
    fire(1);
    rchk("falling", ad(`IDX_STATUS), 32'h0000_0081);
    report_and_stop();
  end
endmodule : tb_top

// [verilog/cond_unit.sv]
`timescale 1ns/10ps
`include "cond_unit_consts.svh"
// Behaviour
// - input test sets true on match, false otherwise
// - condition code readable, never software writable
// - jump taken only when code equals condition
// - register test compares register to test value
// - test values limited per long/short register width
// - each trigger pushes elapsed milliseconds since previous trigger or capture setup, except into a full buffer
// - stamp buffer is eight deep first-in first-out
// - pop moves oldest entry into result register
// - pop on empty buffer writes zero result
// - capture setup empties buffer and arms trigger
// - trigger register counts arrived triggers
module cond_unit #(
  parameter int unsigned MS_CYCLES = `MS_CYCLES
) (
  input wire logic CLK_SYS,
  input wire logic NRST,
  input wire logic [`DIN_W-1:0] DIN,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_AWADDR,
  input wire logic [2:0] S_AXI_AWPROT,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  output logic [1:0] S_AXI_BRESP,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_ARADDR,
  input wire logic [2:0] S_AXI_ARPROT,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output cond_unit_pkg::cc_t COND_CODE,
  output logic JUMP_TAKEN,
  output logic [11:0] JUMP_TARGET
);
  import cond_unit_pkg::*;

  // ========================================================
  // bus write side: address and data latch in either order
  logic aw_have_q;
  logic w_have_q;
  logic [31:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic [31:0] araddr_w;
  wire aw_hs = S_AXI_AWVALID && S_AXI_AWREADY;
  wire w_hs = S_AXI_WVALID && S_AXI_WREADY;
  wire b_hs = S_AXI_BVALID && S_AXI_BREADY;
  wire ar_hs = S_AXI_ARVALID && S_AXI_ARREADY;
  wire r_hs = S_AXI_RVALID && S_AXI_RREADY;
  wire wr_fire = aw_have_q && w_have_q && !S_AXI_BVALID;
  wire [7:0] wr_idx = awaddr_q[`ADDR_IDX_HI:`ADDR_IDX_LO];
  wire wr_inrange = (awaddr_q[31:`ADDR_IDX_HI+1] == '0);
  wire wr_cmd = wr_fire && wr_inrange && (wr_idx == `IDX_CMD);
  wire wr_tval = wr_fire && wr_inrange && (wr_idx == `IDX_TEST_VAL);
  wire wr_cond = wr_fire && wr_inrange && (wr_idx == `IDX_COND);
  wire wr_tcnt = wr_fire && wr_inrange && (wr_idx == `IDX_TRIG_CNT);
  wire wr_stat = wr_fire && wr_inrange && (wr_idx == `IDX_STATUS);
  wire wr_jump = wr_fire && wr_inrange && (wr_idx == `IDX_JUMP);
  wire wr_tsr = wr_fire && wr_inrange && (wr_idx == `IDX_TS_RESULT);
  wire wr_mapped = wr_cmd || wr_tval || wr_cond || wr_tcnt || wr_stat ||
                   wr_jump || wr_tsr;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return res;
  endfunction : merge

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      S_AXI_AWREADY <= 1'b1;
      S_AXI_WREADY <= 1'b1;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= `RST_WORD;
      wdata_q <= `RST_WORD;
      wstrb_q <= '0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= `RESP_OKAY;
    end else begin
      if (aw_hs) begin
        S_AXI_AWREADY <= 1'b0;
        aw_have_q <= 1'b1;
        awaddr_q <= S_AXI_AWADDR;
      end
      if (w_hs) begin
        S_AXI_WREADY <= 1'b0;
        w_have_q <= 1'b1;
        wdata_q <= S_AXI_WDATA;
        wstrb_q <= S_AXI_WSTRB;
      end
      if (wr_fire) begin
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (b_hs) begin
        S_AXI_BVALID <= 1'b0;
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        S_AXI_AWREADY <= 1'b1;
        S_AXI_WREADY <= 1'b1;
      end
    end
  end

  // ========================================================
  // command decode; one write at a time keeps commands in order
  cmd_t cmd;
  assign cmd = cmd_t'(wdata_q);
  wire cmd_go = wr_cmd && wstrb_q[0];
  wire go_in_test = cmd_go && (cmd.op == OP_INPUT_TEST);
  wire go_reg_test = cmd_go && (cmd.op == OP_REG_TEST);
  wire go_pop = cmd_go && (cmd.op == OP_TS_POP);
  wire go_setup = cmd_go && (cmd.op == OP_TRIG_SETUP);
  wire go_jump = cmd_go && (cmd.op == OP_COND_JUMP);

  // ========================================================
  // input pins, trigger detection and millisecond timer
  logic [`DIN_W-1:0] din_s;
  logic armed_q;
  logic [2:0] trig_sel_q;
  logic trig_lvl_q;
  logic trig_prev_q;
  logic [15:0] div_q;
  logic [31:0] elapsed_q;
  logic [15:0] trig_cnt_q;

  din_sync #(
    .WIDTH(`DIN_W)
  ) u_din_sync (
    .clk(CLK_SYS),
    .nrst(NRST),
    .async_in(DIN),
    .sync_out(din_s)
  );

  wire trig_now = din_s[trig_sel_q];
  // level high fires on a rising edge, level low on a falling one
  wire trig = armed_q && !go_setup && (trig_now != trig_prev_q) &&
              (trig_now == trig_lvl_q);
  wire ms_tick = (div_q == 16'(MS_CYCLES - 1));
  wire elapsed_max = (elapsed_q == 32'hFFFF_FFFF);

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      armed_q <= 1'b0;
      trig_sel_q <= '0;
      trig_lvl_q <= 1'b0;
      trig_prev_q <= 1'b0;
    end else if (go_setup) begin
      armed_q <= 1'b1;
      trig_sel_q <= cmd.in_sel;
      trig_lvl_q <= cmd.level;
      trig_prev_q <= din_s[cmd.in_sel];
    end else begin
      trig_prev_q <= trig_now;
    end
  end

  // prescaler restarts with the stamp, so a stamp is whole ms and never
  // carries the divider phase; saturates rather than wraps
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      div_q <= `RST_CNT16;
      elapsed_q <= `RST_WORD;
    end else begin
      div_q <= (ms_tick || go_setup || trig) ? `RST_CNT16 : div_q + 1'b1;
      if (go_setup || trig) begin
        elapsed_q <= `RST_WORD;
      end else if (ms_tick && !elapsed_max) begin
        elapsed_q <= elapsed_q + 1'b1;
      end
    end
  end

  // a trigger in the same cycle as a software write still counts
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      trig_cnt_q <= `RST_CNT16;
    end else if (wr_tcnt) begin
      trig_cnt_q <= 16'(merge({16'h0000, trig_cnt_q}, wdata_q,
                              wstrb_q)) + 16'(trig);
    end else if (trig) begin
      trig_cnt_q <= trig_cnt_q + 1'b1;
    end
  end

  // ========================================================
  // time stamp buffer and result register
  logic [31:0] fifo_rd;
  logic [`TS_CNT_W-1:0] fifo_cnt;
  logic fifo_full;
  logic fifo_empty;
  logic pop_pend_q;
  logic [31:0] ts_result_q;

  ts_fifo u_ts_fifo (
    .clk(CLK_SYS),
    .nrst(NRST),
    .flush(go_setup),
    .push(trig),
    .push_data(elapsed_q),
    .pop(go_pop && !fifo_empty),
    .pop_data(fifo_rd),
    .count(fifo_cnt),
    .full(fifo_full),
    .empty(fifo_empty)
  );

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      pop_pend_q <= 1'b0;
      ts_result_q <= `RST_WORD;
    end else begin
      pop_pend_q <= go_pop && !fifo_empty;
      if (pop_pend_q) begin
        ts_result_q <= fifo_rd;
      end else if (go_pop && fifo_empty) begin
        ts_result_q <= `RST_WORD;
      end else if (wr_tsr) begin
        ts_result_q <= merge(ts_result_q, wdata_q, wstrb_q);
      end
    end
  end

  // ========================================================
  // test value, range check and condition code
  logic [31:0] test_val_q;
  logic err_q;
  logic signed [31:0] sel_val;
  wire signed [31:0] tval = signed'(test_val_q);
  wire sel_short = (cmd.reg_sel == RS_TRIG_CNT) ||
                   (cmd.reg_sel == RS_INPUTS);
  wire long_ok = (test_val_q != `LONG_BAD);
  wire short_ok = (tval <= `SHORT_MAX) && (tval >= `SHORT_MIN);
  wire range_ok = sel_short ? short_ok : long_ok;
  assign sel_val = (cmd.reg_sel == RS_TS_RESULT) ? signed'(ts_result_q) :
                   (cmd.reg_sel == RS_TRIG_CNT) ?
                   signed'({{16{trig_cnt_q[15]}}, trig_cnt_q}) :
                   (cmd.reg_sel == RS_INPUTS) ? signed'({24'h00_0000, din_s}) :
                   signed'(elapsed_q);
  wire cc_t in_cc = (din_s[cmd.in_sel] == cmd.level) ? CC_T : CC_F;
  wire cc_t reg_cc = (sel_val < tval) ? CC_L :
                     (sel_val == tval) ? CC_E : CC_G;
  wire err_clr = wr_stat && wstrb_q[0] && wdata_q[`STATUS_ERR_BIT];

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      test_val_q <= `RST_WORD;
      err_q <= 1'b0;
      COND_CODE <= CC_F;
    end else begin
      if (wr_tval) begin
        test_val_q <= merge(test_val_q, wdata_q, wstrb_q);
      end
      if (go_reg_test && !range_ok) begin
        err_q <= 1'b1;
      end else if (err_clr) begin
        err_q <= 1'b0;
      end
      if (go_in_test) begin
        COND_CODE <= in_cc;
      end else if (go_reg_test && range_ok) begin
        COND_CODE <= reg_cc;
      end
    end
  end

  // ========================================================
  // conditional jump; one-cycle taken pulse with target
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      JUMP_TAKEN <= 1'b0;
      JUMP_TARGET <= '0;
    end else begin
      JUMP_TAKEN <= go_jump && (COND_CODE == cmd.cond);
      if (go_jump && (COND_CODE == cmd.cond)) begin
        JUMP_TARGET <= cmd.target;
      end
    end
  end

  // ========================================================
  // read side: data registered on the same edge that takes the address
  assign araddr_w = S_AXI_ARADDR;
  wire [7:0] rd_idx = araddr_w[`ADDR_IDX_HI:`ADDR_IDX_LO];
  wire rd_inrange = (araddr_w[31:`ADDR_IDX_HI+1] == '0);
  wire [31:0] status_w = {24'h00_0000, armed_q, err_q, fifo_full,
                          fifo_empty, fifo_cnt};
  wire rd_hit_tv = rd_inrange && (rd_idx == `IDX_TEST_VAL);
  wire rd_hit_cc = rd_inrange && (rd_idx == `IDX_COND);
  wire rd_hit_tc = rd_inrange && (rd_idx == `IDX_TRIG_CNT);
  wire rd_hit_st = rd_inrange && (rd_idx == `IDX_STATUS);
  wire rd_hit_jp = rd_inrange && (rd_idx == `IDX_JUMP);
  wire rd_hit_ts = rd_inrange && (rd_idx == `IDX_TS_RESULT);
  wire rd_hit_cm = rd_inrange && (rd_idx == `IDX_CMD);
  wire [31:0] rd_mux =
    rd_hit_tv ? test_val_q :
    rd_hit_cc ? {29'h0000_0000, COND_CODE} :
    rd_hit_tc ? {16'h0000, trig_cnt_q} :
    rd_hit_st ? status_w :
    rd_hit_jp ? {20'h0_0000, JUMP_TARGET} :
    rd_hit_ts ? ts_result_q : `RST_WORD;
  wire rd_mapped = rd_hit_tv || rd_hit_cc || rd_hit_tc || rd_hit_st ||
                   rd_hit_jp || rd_hit_ts || rd_hit_cm;

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      S_AXI_ARREADY <= 1'b1;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= `RST_WORD;
      S_AXI_RRESP <= `RESP_OKAY;
    end else if (ar_hs) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA <= rd_mux;
      S_AXI_RRESP <= rd_mapped ? `RESP_OKAY : `RESP_SLVERR;
    end else if (r_hs) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_ARREADY <= 1'b1;
    end
  end

  // ========================================================
  // checks
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!NRST);

  a_input_test_cc: assert property (
    go_in_test |=> COND_CODE == $past(in_cc))
    else $error("input test left wrong condition code");
  a_cc_read_only: assert property (
    wr_cond && !cmd_go |=> $stable(COND_CODE))
    else $error("condition code changed by a register write");
  a_jump_match: assert property (
    go_jump |=> JUMP_TAKEN == ($past(COND_CODE) == $past(cmd.cond)))
    else $error("jump decision does not follow condition code");
  a_reg_test_cc: assert property (
    go_reg_test && range_ok |=> COND_CODE inside {CC_L, CC_E, CC_G})
    else $error("register test gave no relation code");
  a_range_reject: assert property (
    go_reg_test && !range_ok |=> $stable(COND_CODE) && err_q)
    else $error("out of range test value was used");
  a_trig_push: assert property (
    trig && !fifo_full && !go_pop |=> fifo_cnt == $past(fifo_cnt) + 1)
    else $error("trigger did not push a time stamp");
  a_fifo_depth: assert property (
    fifo_cnt <= `TS_CNT_W'(`TS_DEPTH))
    else $error("time stamp buffer beyond eight entries");
  a_pop_order: assert property (
    go_pop && !fifo_empty |=> ##1 ts_result_q == $past(fifo_rd))
    else $error("pop did not deliver buffer head");
  a_pop_empty: assert property (
    go_pop && fifo_empty |=> ts_result_q == `RST_WORD)
    else $error("pop on empty buffer did not clear result");
  a_setup_flush: assert property (
    go_setup |=> fifo_empty && armed_q)
    else $error("capture setup did not empty and arm");
  a_trig_count: assert property (
    trig && !wr_tcnt |=> trig_cnt_q == $past(trig_cnt_q) + 16'h0001)
    else $error("trigger not counted");
  a_full_drop: assert property (
    trig && fifo_full && !go_pop && !go_setup |=> fifo_full)
    else $error("full buffer changed on a dropped trigger");

  c_jump_taken: cover property (go_jump ##1 JUMP_TAKEN);
  c_fifo_fill: cover property (fifo_full ##1 trig);
  c_pop_empty: cover property (go_pop && fifo_empty);
endmodule : cond_unit

// [verilog/cond_unit_consts.svh]
`ifndef COND_UNIT_CONSTS_SVH
`define COND_UNIT_CONSTS_SVH
// ==========================================================
// register indices (byte address = index * 4)
`define IDX_CMD 8'h00
`define IDX_TEST_VAL 8'h01
`define IDX_COND 8'h02
`define IDX_TRIG_CNT 8'h03
`define IDX_STATUS 8'h04
`define IDX_JUMP 8'h05
`define IDX_TS_RESULT 8'h27
`define ADDR_IDX_HI 9
`define ADDR_IDX_LO 2
// ==========================================================
// reset values and field positions
`define RST_WORD 32'h0000_0000
`define RST_CNT16 16'h0000
`define STATUS_ERR_BIT 6
// ==========================================================
// test value limits
`define LONG_BAD 32'h8000_0000
`define SHORT_MAX 32'sh0000_7FFF
`define SHORT_MIN 32'shFFFF_8001
// ==========================================================
// timing
`define TICK_NS 25
`define MS_NS 1000000
`define MS_CYCLES (`MS_NS / `TICK_NS)
// ==========================================================
// buffer and pins
`define TS_DEPTH 8
`define TS_PTR_W 3
`define TS_CNT_W 4
`define DIN_W 8
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// [verilog/cond_unit_pkg.sv]
package cond_unit_pkg;
  typedef enum logic [2:0] {CC_F, CC_T, CC_L, CC_E, CC_G} cc_t;
  typedef enum logic [3:0] {
    OP_NONE, OP_INPUT_TEST, OP_REG_TEST, OP_TS_POP, OP_TRIG_SETUP,
    OP_COND_JUMP
  } op_t;
  typedef enum logic [1:0] {
    RS_TS_RESULT, RS_TRIG_CNT, RS_INPUTS, RS_ELAPSED
  } reg_sel_t;
  typedef struct packed {
    logic [6:0] rsvd;
    logic [11:0] target;
    cc_t cond;
    reg_sel_t reg_sel;
    logic level;
    logic [2:0] in_sel;
    op_t op;
  } cmd_t;
endpackage : cond_unit_pkg

// [verilog/din_sync.sv]
`timescale 1ns/10ps
module din_sync #(
  parameter int unsigned WIDTH = 8
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;
  // ========================================================
  // two stages; only the second stage is read downstream
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta_q <= '0;
      sync_out <= '0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule : din_sync

// [verilog/ts_fifo.sv]
`timescale 1ns/10ps
`include "cond_unit_consts.svh"
module ts_fifo (
  input wire logic clk,
  input wire logic nrst,
  input wire logic flush,
  input wire logic push,
  input wire logic [31:0] push_data,
  input wire logic pop,
  output logic [31:0] pop_data,
  output logic [`TS_CNT_W-1:0] count,
  output logic full,
  output logic empty
);
  logic [31:0] mem [`TS_DEPTH];
  logic [`TS_PTR_W-1:0] wp_q;
  logic [`TS_PTR_W-1:0] rp_q;
  logic [`TS_CNT_W-1:0] cnt_q;
  wire push_ok = push && !full;
  wire pop_ok = pop && !empty;
  assign full = (cnt_q == `TS_CNT_W'(`TS_DEPTH));
  assign empty = (cnt_q == '0);
  assign count = cnt_q;
  // ========================================================
  // storage, no reset needed on the array
  always_ff @(posedge clk) begin
    if (push_ok && !flush) begin
      mem[wp_q] <= push_data;
    end
  end
  // ========================================================
  // pointers; a push into a full buffer is simply dropped
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
      pop_data <= `RST_WORD;
    end else if (flush) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push_ok) begin
        wp_q <= wp_q + 1'b1;
      end
      if (pop_ok) begin
        rp_q <= rp_q + 1'b1;
        pop_data <= mem[rp_q];
      end
      if (push_ok && !pop_ok) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop_ok && !push_ok) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule : ts_fifo
